// File: hw/fpu_pkg.sv
// constants shared by the floating point unit and its divider
`default_nettype none
package fpu_pkg;
  // ********
  // register map, byte addresses on the 32-bit slave
  // ********
  localparam logic [3:0] ADDR_EXC_ENABLE = 4'h0; // trap enable per flag
  localparam logic [3:0] ADDR_FLOAT_STATUS = 4'h4; // sticky, read clears
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8; // interrupt mask
  localparam logic [4:0] EXC_ENABLE_RST = 5'h00;
  localparam logic [4:0] FLOAT_STATUS_RST = 5'h00;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam int BUSY_BIT = 8; // read-only busy bit in status word
  // ********
  // flag positions, same layout in all three registers
  // ********
  localparam int FLG_DENORM = 0;
  localparam int FLG_INVALID = 1;
  localparam int FLG_DIVZERO = 2;
  localparam int FLG_OVERFLOW = 3;
  localparam int FLG_UNDERFLOW = 4;
  // ********
  // operation codes on the issue port
  // ********
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_MUL = 4'h2;
  localparam logic [3:0] OP_DIV = 4'h3;
  localparam logic [3:0] OP_FP_CMP_LESS = 4'h4;
  localparam logic [3:0] OP_FP_CMP_EQUAL = 4'h5;
  localparam logic [3:0] OP_FP_CMP_LESS_EQUAL = 4'h6;
  localparam logic [3:0] OP_FP_CMP_GREATER = 4'h7;
  localparam logic [3:0] OP_FP_CMP_NOT_EQUAL = 4'h8;
  localparam logic [3:0] OP_FP_CMP_GREATER_EQUAL = 4'h9;
  localparam logic [3:0] OP_FP_CMP_UNORDERED = 4'ha;
  // ********
  // number formats and counts
  // ********
  localparam logic [31:0] CANON_NAN = 32'hffc00000;
  localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
  localparam logic signed [9:0] EXP_MAX = 10'sh0ff;
  localparam logic [4:0] DIV_STEPS = 5'h1b; // quotient bits produced
endpackage
`default_nettype wire

// File: hw/fp_mant_divider.sv
// iterative restoring divider for 24-bit mantissas, one bit per cycle
`default_nettype none
module fp_mant_divider (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [23:0] dividend,
  input wire logic [23:0] divisor,
  output logic done,
  output logic [26:0] quotient,
  output logic sticky
);
  // ********
  // iteration state
  // ********
  logic [24:0] rem_q, rem_d; // partial remainder, below 2*divisor
  logic [26:0] quo_q, quo_d; // quotient bits, msb first
  logic [4:0] cnt_q, cnt_d; // steps still to run
  logic done_q, done_d;
  logic [25:0] diff; // trial subtraction, bit 25 is the borrow

  // next values: one trial subtraction per cycle
  always_comb begin
    rem_d = rem_q;
    quo_d = quo_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    diff = {1'b0, rem_q} - {2'h0, divisor};
    if (start) begin
      // dividend and divisor both carry the hidden one [RQ3]
      rem_d = {1'b0, dividend};
      quo_d = 27'h0;
      cnt_d = fpu_pkg::DIV_STEPS;
    end else if (cnt_q != 5'h0) begin
      if (!diff[25]) begin
        // remainder covers the divisor: quotient bit is one
        rem_d = {diff[23:0], 1'b0};
        quo_d = {quo_q[25:0], 1'b1};
      end else begin
        rem_d = {rem_q[23:0], 1'b0};
        quo_d = {quo_q[25:0], 1'b0};
      end
      cnt_d = cnt_q - 5'h1;
      done_d = (cnt_q == 5'h1);
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rem_q <= 25'h0;
      quo_q <= 27'h0;
      cnt_q <= 5'h0;
      done_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
  assign quotient = quo_q;
  // any remainder left is below the last quotient bit: it feeds rounding
  assign sticky = (rem_q != 25'h0);
endmodule
`default_nettype wire

// File: hw/single_precision_fp_unit.sv
// single precision floating point execution unit with register slave
//
// Functional notes
// RQ1 - round to nearest, ties to even
// RQ2 - operands from and results to general registers
// RQ3 - add, subtract, multiply and divide
// RQ4 - six ordered compares plus unordered compare
// RQ5 - enabled flags trap through processor exception path
// RQ6 - trapped operation never writes destination register
// RQ7 - denormal operand gives quiet NaN, sets flag
// RQ8 - denormal result flushed to signed zero, underflow
// RQ9 - any NaN operand returns fixed canonical NaN
// RQ10 - overflow returns signed infinity even when trapped
// RQ11 - compare writes one when true, else zero
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`default_nettype none
module single_precision_fp_unit (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic issue_valid,
  input wire logic [3:0] issue_op,
  input wire logic [31:0] issue_a,
  input wire logic [31:0] issue_b,
  input wire logic [4:0] issue_rd,
  output logic issue_ready,
  output logic wb_valid,
  output logic [4:0] wb_rd,
  output logic [31:0] wb_data,
  output logic exc_valid,
  output logic [4:0] exc_cause
);
  // ********
  // helper functions
  // ********
  // round a normalised 27-bit mantissa (hidden, 23 frac, g, r, s) [RQ1]
  function automatic logic [33:0] round_pack(input logic s,
      input logic signed [9:0] e, input logic [26:0] m);
    logic up;
    logic [24:0] r;
    logic signed [9:0] e2;
    up = m[2] & (m[3] | m[1] | m[0]); // tie goes to even lsb [RQ1]
    r = {1'b0, m[26:3]} + {24'h0, up};
    e2 = r[24] ? e + 10'sh001 : e;
    if (e2 >= fpu_pkg::EXP_MAX) begin
      return {2'b01, s, 8'hff, 23'h0}; // signed infinity, overflow [RQ10]
    end else if (e2 <= 10'sh000) begin
      return {2'b10, s, 31'h0}; // flush to signed zero, underflow [RQ8]
    end
    return {2'b00, s, e2[7:0], r[24] ? r[23:1] : r[22:0]};
  endfunction

  // align shift that folds lost bits into the sticky lsb
  function automatic logic [26:0] shr_sticky(input logic [26:0] m,
      input logic [7:0] d);
    logic [26:0] lost;
    lost = 27'h0;
    if (d >= 8'h1b) begin
      return {26'h0, |m};
    end
    lost = m & ~(27'h7ffffff << d);
    return (m >> d) | {26'h0, |lost};
  endfunction

  // count leading zeros for renormalising after cancellation
  function automatic logic [4:0] lzc27(input logic [26:0] v);
    logic [4:0] n;
    logic hit;
    n = 5'h0;
    hit = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      if (!hit && !v[i]) begin
        n = n + 5'h1;
      end else begin
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // map to an unsigned key whose order is the numeric order
  function automatic logic [31:0] order_key(input logic [31:0] v);
    if (v[30:0] == 31'h0) begin
      return 32'h80000000; // both zeros compare equal
    end
    return v[31] ? ~v : {1'b1, v[30:0]};
  endfunction

  // ********
  // operation sequencing
  // ********
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIV} state_t;
  state_t st_q, st_d;
  logic [31:0] a_q, a_d, b_q, b_d; // latched register operands [RQ2]
  logic [3:0] op_q, op_d;
  logic [4:0] rd_q, rd_d;
  logic wb_valid_q, wb_valid_d, exc_valid_q, exc_valid_d;
  logic [4:0] wb_rd_q, wb_rd_d, exc_cause_q, exc_cause_d;
  logic [31:0] wb_data_q, wb_data_d;
  logic ready_q, ready_d;
  logic [4:0] exc_en_q, exc_en_d; // trap enables
  logic [4:0] float_status_q, float_status_d; // sticky flags
  logic [4:0] irq_mask_q, irq_mask_d;
  logic [31:0] readdata_q, readdata_d;
  logic wait_q, wait_d, irq_q, irq_d;

  // operand classes
  logic a_nan, b_nan, a_snan, b_snan, a_inf, b_inf, a_zero, b_zero;
  logic a_den, b_den, b_sign_eff, is_cmp;
  // special-case result
  logic spec_hit;
  logic [31:0] spec_res;
  logic [4:0] spec_flg;
  // add datapath
  logic ax_s, ay_s;
  logic [7:0] ax_e, ay_e;
  logic [26:0] ax_m, ay_m, ay_sh, anorm;
  logic [27:0] asum;
  logic [4:0] alz;
  logic signed [9:0] aexp;
  logic [33:0] add_pk;
  // multiply and divide datapath
  logic [47:0] mprod;
  logic signed [9:0] mexp, dexp;
  logic [33:0] mul_pk, div_pk;
  logic div_start, div_done, div_sticky;
  logic [26:0] div_quo;
  // compare
  logic unord, c_lt, c_eq, c_true;
  // finishing mux
  logic fin;
  logic [31:0] fin_res;
  logic [4:0] fin_flg;

  // operand classification and the IEEE special cases
  always_comb begin
    a_nan = (a_q[30:23] == 8'hff) && (a_q[22:0] != 23'h0);
    b_nan = (b_q[30:23] == 8'hff) && (b_q[22:0] != 23'h0);
    a_snan = a_nan && !a_q[22];
    b_snan = b_nan && !b_q[22];
    a_inf = (a_q[30:23] == 8'hff) && (a_q[22:0] == 23'h0);
    b_inf = (b_q[30:23] == 8'hff) && (b_q[22:0] == 23'h0);
    a_zero = (a_q[30:0] == 31'h0);
    b_zero = (b_q[30:0] == 31'h0);
    a_den = (a_q[30:23] == 8'h00) && !a_zero;
    b_den = (b_q[30:23] == 8'h00) && !b_zero;
    b_sign_eff = b_q[31] ^ (op_q == fpu_pkg::OP_SUB);
    is_cmp = (op_q >= fpu_pkg::OP_FP_CMP_LESS);
    spec_hit = 1'b1;
    spec_res = fpu_pkg::CANON_NAN;
    spec_flg = 5'h0;
    if (a_den || b_den) begin
      spec_flg[fpu_pkg::FLG_DENORM] = 1'b1; // [RQ7]
    end else if (a_nan || b_nan) begin
      // never propagate an input payload [RQ9]
      spec_flg[fpu_pkg::FLG_INVALID] = a_snan || b_snan;
    end else if (op_q == fpu_pkg::OP_MUL) begin
      if ((a_inf && b_zero) || (a_zero && b_inf)) begin
        spec_flg[fpu_pkg::FLG_INVALID] = 1'b1;
      end else if (a_inf || b_inf) begin
        spec_res = {a_q[31] ^ b_q[31], 8'hff, 23'h0};
      end else if (a_zero || b_zero) begin
        spec_res = {a_q[31] ^ b_q[31], 31'h0};
      end else begin
        spec_hit = 1'b0;
      end
    end else if (op_q == fpu_pkg::OP_DIV) begin
      if ((a_zero && b_zero) || (a_inf && b_inf)) begin
        spec_flg[fpu_pkg::FLG_INVALID] = 1'b1;
      end else if (a_inf || b_zero) begin
        spec_res = {a_q[31] ^ b_q[31], 8'hff, 23'h0};
        spec_flg[fpu_pkg::FLG_DIVZERO] = b_zero;
      end else if (a_zero || b_inf) begin
        spec_res = {a_q[31] ^ b_q[31], 31'h0};
      end else begin
        spec_hit = 1'b0;
      end
    end else if (a_inf && b_inf && (a_q[31] != b_sign_eff)) begin
      spec_flg[fpu_pkg::FLG_INVALID] = 1'b1; // inf minus inf
    end else if (a_inf) begin
      spec_res = a_q;
    end else if (b_inf) begin
      spec_res = {b_sign_eff, b_q[30:0]};
    end else begin
      spec_hit = 1'b0;
    end
  end

  // add and subtract: align, add, renormalise, round [RQ3]
  always_comb begin
    if (a_q[30:0] >= b_q[30:0]) begin
      {ax_s, ax_e, ay_s, ay_e} = {a_q[31:23], b_sign_eff, b_q[30:23]};
      ax_m = {|a_q[30:23], a_q[22:0], 3'h0};
      ay_m = {|b_q[30:23], b_q[22:0], 3'h0};
    end else begin
      {ax_s, ax_e, ay_s, ay_e} = {b_sign_eff, b_q[30:23], a_q[31:23]};
      ax_m = {|b_q[30:23], b_q[22:0], 3'h0};
      ay_m = {|a_q[30:23], a_q[22:0], 3'h0};
    end
    ay_sh = shr_sticky(ay_m, ax_e - ay_e);
    if (ax_s ^ ay_s) begin
      asum = {1'b0, ax_m} - {1'b0, ay_sh};
    end else begin
      asum = {1'b0, ax_m} + {1'b0, ay_sh};
    end
    alz = lzc27(asum[26:0]);
    if (asum[27]) begin
      anorm = {asum[27:2], |asum[1:0]};
      aexp = $signed({2'b00, ax_e}) + 10'sh001;
    end else begin
      anorm = asum[26:0] << alz;
      aexp = $signed({2'b00, ax_e}) - $signed({5'h0, alz});
    end
    add_pk = round_pack(ax_s, aexp, anorm);
    if (asum == 28'h0) begin
      // exact cancellation gives +0; two like-signed zeros keep sign
      add_pk = {2'b00, ax_s & ay_s, 31'h0};
    end
  end

  // multiply and the exponent side of divide [RQ3]
  always_comb begin
    mprod = {1'b1, a_q[22:0]} * {1'b1, b_q[22:0]};
    mexp = $signed({2'b00, a_q[30:23]}) + $signed({2'b00, b_q[30:23]})
        - fpu_pkg::EXP_BIAS;
    if (mprod[47]) begin
      mul_pk = round_pack(a_q[31] ^ b_q[31], mexp + 10'sh001,
          {mprod[47:22], |mprod[21:0]});
    end else begin
      mul_pk = round_pack(a_q[31] ^ b_q[31], mexp,
          {mprod[46:21], |mprod[20:0]});
    end
    dexp = $signed({2'b00, a_q[30:23]}) - $signed({2'b00, b_q[30:23]})
        + fpu_pkg::EXP_BIAS;
    if (div_quo[26]) begin
      div_pk = round_pack(a_q[31] ^ b_q[31], dexp,
          {div_quo[26:1], div_quo[0] | div_sticky});
    end else begin
      div_pk = round_pack(a_q[31] ^ b_q[31], dexp - 10'sh001,
          {div_quo[25:0], div_sticky});
    end
  end

  // comparisons: integer one or zero to the destination [RQ4]
  always_comb begin
    unord = a_nan || b_nan;
    c_lt = order_key(a_q) < order_key(b_q);
    c_eq = order_key(a_q) == order_key(b_q);
    unique case (op_q)
      fpu_pkg::OP_FP_CMP_LESS: c_true = !unord && c_lt;
      fpu_pkg::OP_FP_CMP_EQUAL: c_true = !unord && c_eq;
      fpu_pkg::OP_FP_CMP_LESS_EQUAL: c_true = !unord && (c_lt || c_eq);
      fpu_pkg::OP_FP_CMP_GREATER: c_true = !unord && !c_lt && !c_eq;
      fpu_pkg::OP_FP_CMP_NOT_EQUAL: c_true = !unord && !c_eq;
      fpu_pkg::OP_FP_CMP_GREATER_EQUAL: c_true = !unord && !c_lt;
      fpu_pkg::OP_FP_CMP_UNORDERED: c_true = unord; // [RQ11]
      default: c_true = 1'b0; // arithmetic codes and codes above 0xa land here; arithmetic results ignore c_true
    endcase
  end

  fp_mant_divider u_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(div_start),
    .dividend({1'b1, a_q[22:0]}),
    .divisor({1'b1, b_q[22:0]}),
    .done(div_done),
    .quotient(div_quo),
    .sticky(div_sticky)
  );

  // issue, execute and write back
  always_comb begin
    st_d = st_q;
    {a_d, b_d, op_d, rd_d} = {a_q, b_q, op_q, rd_q};
    ready_d = ready_q;
    div_start = 1'b0;
    fin = 1'b0;
    fin_res = 32'h0;
    fin_flg = 5'h0;
    if (is_cmp) begin
      // a denormal compare reports its flag and answers false
      fin_res = {31'h0, c_true && !(a_den || b_den)}; // [RQ11]
      fin_flg[fpu_pkg::FLG_DENORM] = a_den || b_den;
    end else if (spec_hit) begin
      fin_res = spec_res;
      fin_flg = spec_flg;
    end else begin
      unique case (op_q)
        fpu_pkg::OP_MUL: {fin_flg[4:3], fin_res} = mul_pk;
        fpu_pkg::OP_DIV: {fin_flg[4:3], fin_res} = div_pk;
        default: {fin_flg[4:3], fin_res} = add_pk;
      endcase
    end
    unique case (st_q)
      ST_IDLE: begin
        if (issue_valid) begin
          // sources come straight from the general registers [RQ2]
          {a_d, b_d, op_d, rd_d} = {issue_a, issue_b, issue_op, issue_rd};
          ready_d = 1'b0;
          st_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (op_q == fpu_pkg::OP_DIV && !spec_hit) begin
          div_start = 1'b1;
          st_d = ST_DIV;
        end else begin
          fin = 1'b1;
        end
      end
      ST_DIV: fin = div_done;
    endcase
    if (fin) begin
      st_d = ST_IDLE;
      ready_d = 1'b1;
    end
    wb_rd_d = fin ? rd_q : wb_rd_q;
    wb_data_d = fin ? fin_res : wb_data_q; // inf kept even when trapped
    exc_cause_d = fin ? (fin_flg & exc_en_q) : exc_cause_q;
    exc_valid_d = fin && ((fin_flg & exc_en_q) != 5'h0); // [RQ5]
    wb_valid_d = fin && ((fin_flg & exc_en_q) == 5'h0); // [RQ6]
  end

  // ********
  // register slave with interrupt
  // ********

  // one wait cycle per access; data is ready when waitrequest drops
  always_comb begin
    exc_en_d = exc_en_q;
    irq_mask_d = irq_mask_q;
    float_status_d = float_status_q;
    readdata_d = readdata_q;
    wait_d = !((read || write) && wait_q);
    if (read && wait_q) begin
      unique case (address)
        fpu_pkg::ADDR_EXC_ENABLE: readdata_d = {27'h0, exc_en_q};
        fpu_pkg::ADDR_FLOAT_STATUS: begin
          readdata_d = {27'h0, float_status_q};
          readdata_d[fpu_pkg::BUSY_BIT] = !ready_q;
        end
        fpu_pkg::ADDR_IRQ_MASK: readdata_d = {27'h0, irq_mask_q};
        default: readdata_d = 32'h0; // unmapped reads as zero
      endcase
    end
    if (write && !wait_q) begin
      if (address == fpu_pkg::ADDR_EXC_ENABLE) begin
        exc_en_d = writedata[4:0];
      end
      if (address == fpu_pkg::ADDR_IRQ_MASK) begin
        irq_mask_d = writedata[4:0];
      end
    end
    // read clears, but a flag raised in the same cycle survives
    if (read && !wait_q && address == fpu_pkg::ADDR_FLOAT_STATUS) begin
      float_status_d = 5'h0;
    end
    if (fin) begin
      float_status_d = float_status_d | fin_flg; // [RQ7] [RQ8]
    end
    irq_d = (float_status_d & irq_mask_d) != 5'h0;
  end

  // all state registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      {a_q, b_q, op_q, rd_q} <= 73'h0;
      ready_q <= 1'b1;
      wb_valid_q <= 1'b0;
      wb_rd_q <= 5'h0;
      wb_data_q <= 32'h0;
      exc_valid_q <= 1'b0;
      exc_cause_q <= 5'h0;
      exc_en_q <= fpu_pkg::EXC_ENABLE_RST;
      float_status_q <= fpu_pkg::FLOAT_STATUS_RST;
      irq_mask_q <= fpu_pkg::IRQ_MASK_RST;
      readdata_q <= 32'h0;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      {a_q, b_q, op_q, rd_q} <= {a_d, b_d, op_d, rd_d};
      ready_q <= ready_d;
      wb_valid_q <= wb_valid_d;
      wb_rd_q <= wb_rd_d;
      wb_data_q <= wb_data_d;
      exc_valid_q <= exc_valid_d;
      exc_cause_q <= exc_cause_d;
      exc_en_q <= exc_en_d;
      float_status_q <= float_status_d;
      irq_mask_q <= irq_mask_d;
      readdata_q <= readdata_d;
      wait_q <= wait_d;
      irq_q <= irq_d;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = wait_q;
  assign irq = irq_q;
  assign issue_ready = ready_q;
  assign wb_valid = wb_valid_q;
  assign wb_rd = wb_rd_q;
  assign wb_data = wb_data_q;
  assign exc_valid = exc_valid_q;
  assign exc_cause = exc_cause_q;
endmodule
`default_nettype wire

// File: verification/fpu_props.sv
// assertion checker for the floating point unit ports
`default_nettype none
module fpu_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic irq,
  input wire logic issue_valid,
  input wire logic [3:0] issue_op,
  input wire logic [31:0] issue_a,
  input wire logic [31:0] issue_b,
  input wire logic issue_ready,
  input wire logic wb_valid,
  input wire logic [31:0] wb_data,
  input wire logic exc_valid,
  input wire logic [4:0] exc_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // operands of the op in flight, kept for checking at completion
  // ********
  logic [3:0] op_q, op_d;
  logic [31:0] a_q, a_d, b_q, b_d;
  logic take, fin, nan_in, den_in;
  function automatic logic is_nan(input logic [31:0] x);
    return x[30:23] == 8'hff && x[22:0] != 23'h0;
  endfunction
  function automatic logic is_den(input logic [31:0] x);
    return x[30:23] == 8'h00 && x[22:0] != 23'h0;
  endfunction
  assign take = issue_valid && issue_ready;
  assign fin = wb_valid || exc_valid;
  assign nan_in = is_nan(a_q) || is_nan(b_q);
  assign den_in = is_den(a_q) || is_den(b_q);
  // hold unless an op is accepted; the pulse edge still sees the old op
  always_comb begin
    op_d = take ? issue_op : op_q;
    a_d = take ? issue_a : a_q;
    b_d = take ? issue_b : b_q;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= 4'h0;
      a_q <= 32'h0;
      b_q <= 32'h0;
    end else begin
      op_q <= op_d;
      a_q <= a_d;
      b_q <= b_d;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ********
  // assertions
  // ********
  AST_DONE_BOUND: assert property (take |-> ##[2:30] fin)
    else $error("operation did not complete in time");
  AST_EXC_NO_WB: assert property (exc_valid |-> !wb_valid)
    else $error("writeback with a taken exception");
  AST_EXC_CAUSE: assert property (exc_valid |-> exc_cause != 5'h00)
    else $error("exception without a cause");
  AST_OVF_INF: assert property (exc_valid && exc_cause[3] |->
    wb_data[30:0] == 31'h7f800000) else $error("overflow not infinity");
  AST_FTZ: assert property (exc_valid && exc_cause[4] |->
    wb_data[30:0] == 31'h0) else $error("underflow not flushed");
  AST_NAN_CANON: assert property (fin && op_q <= 4'h3 && nan_in &&
    !den_in |-> wb_data == fpu_pkg::CANON_NAN)
    else $error("nan operand gave other pattern");
  AST_DEN_QNAN: assert property (fin && op_q <= 4'h3 && den_in |->
    wb_data[30:22] == 9'h1ff) else $error("denormal gave no quiet nan");
  AST_CMP_BOOL: assert property (wb_valid && op_q >= 4'h4 |->
    wb_data[31:1] == 31'h0) else $error("compare result not 0 or 1");
  AST_UNORD: assert property (wb_valid && op_q == 4'ha && !den_in |->
    wb_data[0] == nan_in) else $error("unordered compare wrong");
  // main scenarios reached
  cover property (exc_valid && exc_cause[3]);
  cover property (wb_valid && op_q == fpu_pkg::OP_DIV);
  cover property (irq);
endmodule
bind single_precision_fp_unit fpu_props u_props (
  .core_clk(core_clk), .resetn(resetn), .irq(irq),
  .issue_valid(issue_valid), .issue_op(issue_op), .issue_a(issue_a),
  .issue_b(issue_b), .issue_ready(issue_ready), .wb_valid(wb_valid),
  .wb_data(wb_data), .exc_valid(exc_valid), .exc_cause(exc_cause)
);
`default_nettype wire

// File: verification/gpr_file_model.sv
// general register file model standing for the processor beside the unit
`default_nettype none
module gpr_file_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_valid,
  input wire logic [4:0] wb_rd,
  input wire logic [31:0] wb_data,
  input wire logic exc_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs_q [32]; // shared by integer and float results
  logic [7:0] trap_cnt_q; // traps seen by the exception path
  // results land only on a writeback pulse; a trap leaves rd untouched
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) regs_q[i] <= 32'h0;
      trap_cnt_q <= 8'h00;
    end else begin
      if (wb_valid) regs_q[wb_rd] <= wb_data;
      if (exc_valid) trap_cnt_q <= trap_cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the floating point unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ONE = 32'h3f800000;
  localparam logic [31:0] TWO = 32'h40000000;
  localparam logic [6:0] CMP_EXP = 7'h15; // 1.0 against 2.0, per op
  logic core_clk, resetn, read, write, issue_valid, waitrequest, irq;
  logic issue_ready, wb_valid, exc_valid, ex_s;
  logic [3:0] address, issue_op;
  logic [31:0] writedata, issue_a, issue_b, readdata, wb_data, r_s, q_s;
  logic [4:0] issue_rd, wb_rd, exc_cause, cause_s;
  int errors, compares;
  single_precision_fp_unit u_dut (.core_clk(core_clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .issue_valid(issue_valid), .issue_op(issue_op), .issue_a(issue_a),
    .issue_b(issue_b), .issue_rd(issue_rd), .issue_ready(issue_ready),
    .wb_valid(wb_valid), .wb_rd(wb_rd), .wb_data(wb_data),
    .exc_valid(exc_valid), .exc_cause(exc_cause));
  gpr_file_model u_gpr (.core_clk(core_clk), .resetn(resetn),
    .wb_valid(wb_valid), .wb_rd(wb_rd), .wb_data(wb_data),
    .exc_valid(exc_valid));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ********
  // shared tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one access held until waitrequest is sampled low, then an idle edge;
  // a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    {read, write, address, writedata} <= {~wr, wr, a, d};
    do @(posedge core_clk);
    while (waitrequest !== 1'b0);
    q_s = readdata;
    {read, write} <= 2'b00;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("readdata", q_s, exp);
  endtask
  // issue one op and wait for its writeback or trap pulse
  task automatic op(input logic [3:0] c, input logic [31:0] a, b,
    input logic [4:0] rd);
    {issue_op, issue_a, issue_b, issue_rd} <= {c, a, b, rd};
    issue_valid <= 1'b1;
    do @(posedge core_clk);
    while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    do @(posedge core_clk);
    while (wb_valid !== 1'b1 && exc_valid !== 1'b1);
    r_s = wb_data;
    ex_s = exc_valid;
    cause_s = exc_cause;
  endtask
  task automatic run(input logic [3:0] c, input logic [31:0] a, b, exp);
    op(c, a, b, 5'd1);
    @(posedge core_clk);
    chk("wb_data", r_s, exp);
    chk("exc_valid", 32'(ex_s), 32'h0);
    chk("gpr", u_gpr.regs_q[1], exp);
  endtask
  // trapped op: cause, unmasked irq, sticky status cleared by its read
  task automatic trap(input logic [3:0] c, input logic [31:0] a, b,
    input logic [4:0] cause);
    op(c, a, b, 5'd31);
    @(posedge core_clk);
    chk("exc_valid", 32'(ex_s), 32'h1);
    chk("exc_cause", 32'(cause_s), 32'(cause));
    chk("irq", 32'(irq), 32'(cause[3]));
    rd_chk(fpu_pkg::ADDR_FLOAT_STATUS, 32'(cause));
    @(posedge core_clk);
    chk("irq", 32'(irq), 32'h0);
  endtask
  // ********
  // watchdog and main sequence
  // ********
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    issue_valid = 1'b0;
    issue_op = 4'h0;
    issue_a = 32'h0;
    issue_b = 32'h0;
    issue_rd = 5'h0;
    errors = 0;
    compares = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // status is read-only and 0xc unmapped: both writes vanish
    bus(1'b1, fpu_pkg::ADDR_FLOAT_STATUS, 32'h1f);
    bus(1'b1, 4'hc, 32'h1f);
    rd_chk(fpu_pkg::ADDR_EXC_ENABLE, 32'h0);
    rd_chk(fpu_pkg::ADDR_FLOAT_STATUS, 32'h0);
    rd_chk(fpu_pkg::ADDR_IRQ_MASK, 32'h0);
    rd_chk(4'hc, 32'h0);
    run(fpu_pkg::OP_ADD, ONE, TWO, 32'h40400000);
    run(fpu_pkg::OP_SUB, 32'h40400000, ONE, TWO);
    run(fpu_pkg::OP_MUL, 32'h3fc00000, TWO, 32'h40400000);
    run(fpu_pkg::OP_DIV, ONE, 32'h40800000, 32'h3e800000);
    // exact ties: down to even, then up to even
    run(fpu_pkg::OP_ADD, ONE, 32'h33800000, ONE);
    run(fpu_pkg::OP_ADD, ONE, 32'h34400000, 32'h3f800002);
    for (int i = 0; i < 7; i++) begin
      run(fpu_pkg::OP_FP_CMP_LESS + 4'(i), ONE, TWO, 32'(CMP_EXP[i]));
    end
    run(fpu_pkg::OP_FP_CMP_EQUAL, 32'h0, 32'h80000000, 32'h1);
    run(fpu_pkg::OP_FP_CMP_UNORDERED, 32'h7fc00000, ONE, 32'h1);
    run(fpu_pkg::OP_FP_CMP_LESS, 32'h7fc00000, ONE, 32'h0);
    run(fpu_pkg::OP_ADD, 32'h7fc00001, ONE, 32'hffc00000);
    run(fpu_pkg::OP_MUL, ONE, 32'hffc12345, 32'hffc00000);
    op(fpu_pkg::OP_ADD, 32'h00000001, ONE, 5'd2);
    @(posedge core_clk);
    chk("quiet_nan", 32'(r_s[30:22]), 32'h1ff);
    rd_chk(fpu_pkg::ADDR_FLOAT_STATUS, 32'h1);
    run(fpu_pkg::OP_MUL, 32'h80800000, 32'h3f000000, 32'h80000000);
    rd_chk(fpu_pkg::ADDR_FLOAT_STATUS, 32'h10);
    // every flag trapped in turn, only overflow unmasked to irq
    bus(1'b1, fpu_pkg::ADDR_EXC_ENABLE, 32'h1f);
    bus(1'b1, fpu_pkg::ADDR_IRQ_MASK, 32'h08);
    rd_chk(fpu_pkg::ADDR_EXC_ENABLE, 32'h1f);
    trap(fpu_pkg::OP_MUL, 32'h7f7fffff, TWO, 5'h08);
    chk("wb_data", r_s, 32'h7f800000);
    trap(fpu_pkg::OP_MUL, 32'hff7fffff, TWO, 5'h08);
    chk("wb_data", r_s, 32'hff800000);
    trap(fpu_pkg::OP_DIV, ONE, 32'h0, 5'h04);
    trap(fpu_pkg::OP_SUB, 32'h7f800000, 32'h7f800000, 5'h02);
    trap(fpu_pkg::OP_ADD, 32'h00000001, ONE, 5'h01);
    trap(fpu_pkg::OP_MUL, 32'h00800000, 32'h3f000000, 5'h10);
    chk("gpr31", u_gpr.regs_q[31], 32'h0);
    chk("traps", 32'(u_gpr.trap_cnt_q), 32'h6);
    bus(1'b1, fpu_pkg::ADDR_EXC_ENABLE, 32'h0);
    run(fpu_pkg::OP_MUL, 32'h7f7fffff, TWO, 32'h7f800000);
    rd_chk(fpu_pkg::ADDR_FLOAT_STATUS, 32'h08);
    end_of_test();
  end
endmodule
`default_nettype wire
